// File: inc/lcdreg_pkg.sv
// Shared constants and types for the display control register bank and its host controller.
package lcdreg_pkg;
  // **********
  // Register offsets and reset values
  // **********
  localparam logic [7:0] REG_DISP = 8'h09;
  localparam logic [7:0] REG_ATTR = 8'h0A;
  localparam logic [7:0] REG_S1_LO = 8'h0B;
  localparam logic [7:0] REG_S1_HI = 8'h0C;
  localparam logic [7:0] REG_L1 = 8'h0D;
  localparam logic [7:0] REG_S2_LO = 8'h0E;
  localparam logic [7:0] REG_S2_HI = 8'h0F;
  localparam logic [7:0] REG_L2 = 8'h10;
  localparam logic [7:0] REG_SCROLL_LAST = 8'h14;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [14:0] RST_ADDR = 15'h0000;
  localparam int GATE_BIT = 7;
  // **********
  // Indirect command codes
  // **********
  localparam logic [7:0] CMD_DISP_OFF = 8'h10;
  localparam logic [7:0] CMD_DISP_ON = 8'h11;
  localparam logic [7:0] CMD_SCROLL = 8'h20;
  // **********
  // Flash timing
  // **********
  localparam int FLASH_SLOW_BIT = 4;
  localparam int FLASH_FAST_BIT = 1;
  localparam logic [4:0] CUR_SLOW_ON = 5'h16;
  localparam logic [5:0] CUR_VSLOW_ON = 6'h2D;
  // **********
  // Host timing and register map
  // **********
  localparam int CLK_HZ = 50000000;
  localparam int OFF_WAIT_MS = 50;
  localparam int OFF_WAIT_CYC = OFF_WAIT_MS * (CLK_HZ / 1000);
  localparam logic [3:0] HOST_REQ = 4'h0;
  localparam logic [3:0] HOST_STAT = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    KIND_REG = 2'b00,
    KIND_CMD = 2'b01,
    KIND_PAR = 2'b10,
    KIND_MEM = 2'b11
  } lcdreg_kind_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_SEND = 2'b10,
    ST_WAIT = 2'b11
  } lcdreg_state_type;
endpackage

// File: inc/lcdreg_link_if.sv
// Parallel host link between the controller and the display control register bank.
`timescale 1ns/1ps
interface lcdreg_link_if (
  input wire logic core_clk
);
  logic stb;
  logic wr;
  lcdreg_pkg::lcdreg_kind_type kind;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport dev (
    input stb,
    input wr,
    input kind,
    input addr,
    input wdata,
    output rdata,
    output ack
  );
  modport host (
    output stb,
    output wr,
    output kind,
    output addr,
    output wdata,
    input rdata,
    input ack
  );
endinterface

// File: rtl/lcdreg_flash.sv
// Frame counter and visibility decode for screen blocks and cursor.
`timescale 1ns/1ps
module lcdreg_flash (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic frame_tick,
  input wire logic enable,
  input wire logic dual_panel,
  input wire logic [7:0] attr,
  output logic blk1_vis,
  output logic blk2_vis,
  output logic blk3_vis,
  output logic blk4_vis,
  output logic cursor_vis
);
  logic [5:0] cnt_reg;

  function automatic logic blk_vis(input logic [1:0] a, input logic [5:0] c);
    case (a)
      2'b00: blk_vis = 1'b0;
      2'b01: blk_vis = 1'b1;
      2'b10: blk_vis = ~c[lcdreg_pkg::FLASH_SLOW_BIT];
      default: blk_vis = ~c[lcdreg_pkg::FLASH_FAST_BIT];
    endcase
  endfunction

  // **********
  // Frame counter
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 6'h00;
    end else if (frame_tick) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // **********
  // Visibility
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blk1_vis <= 1'b0;
      blk2_vis <= 1'b0;
      blk3_vis <= 1'b0;
      blk4_vis <= 1'b0;
      cursor_vis <= 1'b0;
    end else begin
      blk3_vis <= enable & blk_vis(attr[7:6], cnt_reg);
      blk2_vis <= enable & blk_vis(attr[5:4], cnt_reg);
      blk4_vis <= enable & dual_panel & blk_vis(attr[5:4], cnt_reg);
      blk1_vis <= enable & blk_vis(attr[3:2], cnt_reg);
      case (attr[1:0])
        2'b00: cursor_vis <= 1'b0;
        2'b01: cursor_vis <= enable;
        2'b10: cursor_vis <= enable & (cnt_reg[4:0] < lcdreg_pkg::CUR_SLOW_ON);
        default: cursor_vis <= enable & (cnt_reg < lcdreg_pkg::CUR_VSLOW_ON);
      endcase
    end
  end
endmodule // lcdreg_flash

// File: rtl/lcdreg_dev.sv
// Display control register bank: enable, attributes, block start addresses and sizes.
`timescale 1ns/1ps
// Notes on behaviour
// - Enable bit switches whole panel output.
// - Enable off overrides every attribute setting.
// - Host waits 50 ms after its own turn-off before re-enabling; power save entry is not timed.
// - Third block attribute: blank, steady, flashes.
// - Second block attribute also drives fourth.
// - First block attribute uses same encoding.
// - Cursor attribute: blank, steady, slow flashes.
// - Flashing cursor shown seventy percent.
// - Memory write enables cursor and advances.
// - Memory read advances, leaves cursor off.
// - Block one start is fifteen bits.
// - Low byte first; high byte commits.
// - Gate bit defers commit to permit.
// - Block one size holds lines minus one.
// - On/off command parameters load attributes.
// - Scroll command parameters load start registers.
// - Power save entry clears enable bit.
module lcdreg_dev (
  input wire logic core_clk,
  input wire logic nrst,
  lcdreg_link_if.dev lk,
  input wire logic frame_tick,
  input wire logic dual_panel,
  input wire logic scroll_permit,
  input wire logic pwr_save,
  output logic blk1_vis,
  output logic blk2_vis,
  output logic blk3_vis,
  output logic blk4_vis,
  output logic cursor_vis,
  output logic panel_on,
  output logic [14:0] block1_start,
  output logic [14:0] block2_start,
  output logic [7:0] block1_lines,
  output logic [7:0] block2_lines,
  output logic [14:0] cursor_addr
);
  logic disp_on_reg;
  logic [7:0] attr_reg;
  logic [7:0] s1_lo_reg;
  logic [7:0] s1_hi_reg;
  logic [7:0] s2_lo_reg;
  logic [7:0] s2_hi_reg;
  logic [7:0] l1_reg;
  logic [7:0] l2_reg;
  logic [14:0] live1_reg;
  logic [14:0] live2_reg;
  logic pend1_reg;
  logic pend2_reg;
  logic [7:0] par_ptr_reg;
  logic [7:0] par_end_reg;
  logic [14:0] cur_reg;
  logic pwr_q_reg;
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic reg_wr;
  logic par_wr;
  logic cmd_wr;
  logic mem_acc;
  logic w_en;
  logic [7:0] w_addr;
  logic commit1;
  logic commit2;

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      lcdreg_pkg::REG_DISP: rd_mux = {7'h00, disp_on_reg};
      lcdreg_pkg::REG_ATTR: rd_mux = attr_reg;
      lcdreg_pkg::REG_S1_LO: rd_mux = s1_lo_reg;
      lcdreg_pkg::REG_S1_HI: rd_mux = s1_hi_reg;
      lcdreg_pkg::REG_L1: rd_mux = l1_reg;
      lcdreg_pkg::REG_S2_LO: rd_mux = s2_lo_reg;
      lcdreg_pkg::REG_S2_HI: rd_mux = s2_hi_reg;
      lcdreg_pkg::REG_L2: rd_mux = l2_reg;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // **********
  // Request decode
  // **********
  // Bytes past a command's list are dropped, so they cannot spill elsewhere.
  always_comb begin
    reg_wr = lk.stb & lk.wr & (lk.kind == lcdreg_pkg::KIND_REG);
    cmd_wr = lk.stb & lk.wr & (lk.kind == lcdreg_pkg::KIND_CMD);
    par_wr = lk.stb & lk.wr & (lk.kind == lcdreg_pkg::KIND_PAR) & (par_ptr_reg <= par_end_reg);
    mem_acc = lk.stb & (lk.kind == lcdreg_pkg::KIND_MEM);
    w_en = reg_wr | par_wr;
    w_addr = par_wr ? par_ptr_reg : lk.addr;
    commit1 = pend1_reg & (~s1_hi_reg[lcdreg_pkg::GATE_BIT] | scroll_permit);
    commit2 = pend2_reg & (~s2_hi_reg[lcdreg_pkg::GATE_BIT] | scroll_permit);
  end

  // **********
  // Link answer
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rdata_reg <= lcdreg_pkg::RST_BYTE;
    end else begin
      ack_reg <= lk.stb;
      if (lk.stb && !lk.wr && lk.kind == lcdreg_pkg::KIND_REG) begin
        rdata_reg <= rd_mux(lk.addr);
      end else if (lk.stb) begin
        rdata_reg <= lcdreg_pkg::RST_BYTE;
      end
    end
  end
  assign lk.ack = ack_reg;
  assign lk.rdata = rdata_reg;

  // **********
  // Display enable
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      disp_on_reg <= 1'b0;
      pwr_q_reg <= 1'b0;
    end else begin
      pwr_q_reg <= pwr_save;
      if (pwr_save && !pwr_q_reg) begin
        disp_on_reg <= 1'b0;
      end else if (w_en && w_addr == lcdreg_pkg::REG_DISP) begin
        disp_on_reg <= lk.wdata[0];
      end else if (cmd_wr && lk.addr == lcdreg_pkg::CMD_DISP_ON) begin
        disp_on_reg <= 1'b1;
      end else if (cmd_wr && lk.addr == lcdreg_pkg::CMD_DISP_OFF) begin
        disp_on_reg <= 1'b0;
      end
    end
  end
  assign panel_on = disp_on_reg;

  // **********
  // Indirect parameter pointer
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      par_ptr_reg <= 8'h01;
      par_end_reg <= 8'h00;
    end else if (cmd_wr) begin
      case (lk.addr)
        lcdreg_pkg::CMD_DISP_ON, lcdreg_pkg::CMD_DISP_OFF: begin
          par_ptr_reg <= lcdreg_pkg::REG_ATTR;
          par_end_reg <= lcdreg_pkg::REG_ATTR;
        end
        lcdreg_pkg::CMD_SCROLL: begin
          par_ptr_reg <= lcdreg_pkg::REG_S1_LO;
          par_end_reg <= lcdreg_pkg::REG_SCROLL_LAST;
        end
        default: begin
          par_ptr_reg <= 8'h01;
          par_end_reg <= 8'h00;
        end
      endcase
    end else if (par_wr) begin
      par_ptr_reg <= par_ptr_reg + 8'h01;
    end
  end

  // **********
  // Attributes and cursor
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      attr_reg <= lcdreg_pkg::RST_BYTE;
    end else if (w_en && w_addr == lcdreg_pkg::REG_ATTR) begin
      attr_reg <= lk.wdata;
    end else if (mem_acc && lk.wr && attr_reg[1:0] == 2'b00) begin
      attr_reg[1:0] <= 2'b01;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cur_reg <= lcdreg_pkg::RST_ADDR;
    end else if (mem_acc) begin
      cur_reg <= cur_reg + 15'h0001;
    end
  end
  assign cursor_addr = cur_reg;

  // **********
  // Start addresses and sizes
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_lo_reg <= lcdreg_pkg::RST_BYTE;
      s1_hi_reg <= lcdreg_pkg::RST_BYTE;
      l1_reg <= lcdreg_pkg::RST_BYTE;
      s2_lo_reg <= lcdreg_pkg::RST_BYTE;
      s2_hi_reg <= lcdreg_pkg::RST_BYTE;
      l2_reg <= lcdreg_pkg::RST_BYTE;
    end else if (w_en) begin
      case (w_addr)
        lcdreg_pkg::REG_S1_LO: s1_lo_reg <= lk.wdata;
        lcdreg_pkg::REG_S1_HI: s1_hi_reg <= lk.wdata;
        lcdreg_pkg::REG_L1: l1_reg <= lk.wdata;
        lcdreg_pkg::REG_S2_LO: s2_lo_reg <= lk.wdata;
        lcdreg_pkg::REG_S2_HI: s2_hi_reg <= lk.wdata;
        lcdreg_pkg::REG_L2: l2_reg <= lk.wdata;
        default: ;
      endcase
    end
  end
  assign block1_lines = l1_reg;
  assign block2_lines = l2_reg;

  // A new high byte beats a same-cycle commit, so it is never lost.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend1_reg <= 1'b0;
      live1_reg <= lcdreg_pkg::RST_ADDR;
    end else begin
      if (w_en && w_addr == lcdreg_pkg::REG_S1_HI) begin
        pend1_reg <= 1'b1;
      end else if (commit1) begin
        pend1_reg <= 1'b0;
      end
      if (commit1) begin
        live1_reg <= {s1_hi_reg[6:0], s1_lo_reg};
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend2_reg <= 1'b0;
      live2_reg <= lcdreg_pkg::RST_ADDR;
    end else begin
      if (w_en && w_addr == lcdreg_pkg::REG_S2_HI) begin
        pend2_reg <= 1'b1;
      end else if (commit2) begin
        pend2_reg <= 1'b0;
      end
      if (commit2) begin
        live2_reg <= {s2_hi_reg[6:0], s2_lo_reg};
      end
    end
  end
  assign block1_start = live1_reg;
  assign block2_start = live2_reg;

  // **********
  // Panel visibility
  // **********
  lcdreg_flash i_lcdreg_flash (
    .core_clk(core_clk),
    .nrst(nrst),
    .frame_tick(frame_tick),
    .enable(disp_on_reg),
    .dual_panel(dual_panel),
    .attr(attr_reg),
    .blk1_vis(blk1_vis),
    .blk2_vis(blk2_vis),
    .blk3_vis(blk3_vis),
    .blk4_vis(blk4_vis),
    .cursor_vis(cursor_vis)
  );
endmodule // lcdreg_dev

// File: rtl/lcdreg_host.sv
// Host controller: AXI4-Lite slave that issues link transactions to the register bank.
`timescale 1ns/1ps
module lcdreg_host #(
  parameter int OFF_WAIT = lcdreg_pkg::OFF_WAIT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  lcdreg_link_if.host lk,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  lcdreg_pkg::lcdreg_state_type state_reg;
  logic [3:0] awaddr_reg;
  logic [18:0] wdata_reg;
  logic [18:0] req_reg;
  logic [7:0] last_rd_reg;
  logic [22:0] off_cnt_reg;
  logic stb_reg;
  logic do_wr;
  logic launch;
  logic turns_on;
  logic turns_off;

  // Request word: [7:0] address or command, [15:8] data, [17:16] kind, [18] write.
  always_comb begin
    do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    launch = do_wr & (awaddr_reg == lcdreg_pkg::HOST_REQ) & (state_reg == lcdreg_pkg::ST_IDLE);
    turns_on = req_reg[18] & ((req_reg[17:16] == 2'b00 && req_reg[7:0] == lcdreg_pkg::REG_DISP
      && req_reg[8]) || (req_reg[17:16] == 2'b01 && req_reg[7:0] == lcdreg_pkg::CMD_DISP_ON));
    turns_off = req_reg[18] & ((req_reg[17:16] == 2'b00 && req_reg[7:0] == lcdreg_pkg::REG_DISP
      && !req_reg[8]) || (req_reg[17:16] == 2'b01 && req_reg[7:0] == lcdreg_pkg::CMD_DISP_OFF));
  end

  // **********
  // AXI4-Lite write channels
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lcdreg_pkg::RESP_OKAY;
      awaddr_reg <= 4'h0;
      wdata_reg <= 19'h00000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata[18:0];
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= launch ? lcdreg_pkg::RESP_OKAY : lcdreg_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // **********
  // AXI4-Lite read channels
  // **********
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= lcdreg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        lcdreg_pkg::HOST_REQ: begin
          s_axi_rdata <= {13'h0000, req_reg};
          s_axi_rresp <= lcdreg_pkg::RESP_OKAY;
        end
        lcdreg_pkg::HOST_STAT: begin
          s_axi_rdata <= {16'h0000, last_rd_reg, 6'h00, state_reg == lcdreg_pkg::ST_HOLD,
            state_reg != lcdreg_pkg::ST_IDLE};
          s_axi_rresp <= lcdreg_pkg::RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= lcdreg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // **********
  // Link sequencer
  // **********
  // Early re-enable after a host-issued turn-off is held here; after power save entry, software must time it.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= lcdreg_pkg::ST_IDLE;
      req_reg <= 19'h00000;
      stb_reg <= 1'b0;
      last_rd_reg <= 8'h00;
    end else begin
      stb_reg <= 1'b0;
      case (state_reg)
        lcdreg_pkg::ST_IDLE: begin
          if (launch) begin
            req_reg <= wdata_reg;
            state_reg <= lcdreg_pkg::ST_HOLD;
          end
        end
        lcdreg_pkg::ST_HOLD: begin
          if (!turns_on || off_cnt_reg == 23'h000000) begin
            stb_reg <= 1'b1;
            state_reg <= lcdreg_pkg::ST_WAIT;
          end
        end
        lcdreg_pkg::ST_WAIT: begin
          if (lk.ack) begin
            last_rd_reg <= lk.rdata;
            state_reg <= lcdreg_pkg::ST_IDLE;
          end
        end
        default: state_reg <= lcdreg_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      off_cnt_reg <= 23'h000000;
    end else if (state_reg == lcdreg_pkg::ST_HOLD && !turns_on && turns_off) begin
      off_cnt_reg <= 23'(OFF_WAIT);
    end else if (off_cnt_reg != 23'h000000) begin
      off_cnt_reg <= off_cnt_reg - 23'h000001;
    end
  end

  assign lk.stb = stb_reg;
  assign lk.wr = req_reg[18];
  assign lk.kind = lcdreg_pkg::lcdreg_kind_type'(req_reg[17:16]);
  assign lk.addr = req_reg[7:0];
  assign lk.wdata = req_reg[15:8];
endmodule // lcdreg_host

// File: verif/lcdreg_asserts.sv
// Concurrent checks on the host link and on the outputs of the register bank.
`timescale 1ns/1ps
module lcdreg_asserts #(
  parameter int OFF_WAIT = 50
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic stb,
  input wire logic wr,
  input wire lcdreg_pkg::lcdreg_kind_type kind,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic pwr_save,
  input wire logic scroll_permit,
  input wire logic panel_on,
  input wire logic blk1_vis,
  input wire logic blk2_vis,
  input wire logic blk3_vis,
  input wire logic blk4_vis,
  input wire logic cursor_vis,
  input wire logic [14:0] block1_start,
  input wire logic [7:0] block1_lines,
  input wire logic [14:0] cursor_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic wreg;
  int off_cnt;
  assign wreg = stb && wr && (kind == lcdreg_pkg::KIND_REG);
  // Dark time saturates, so it never wraps.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      off_cnt <= OFF_WAIT;
    end else if (panel_on) begin
      off_cnt <= 0;
    end else if (off_cnt < OFF_WAIT) begin
      off_cnt <= off_cnt + 1;
    end
  end
  // **********
  // Properties
  // **********
  property p_ack_pulse;
    stb |=> ack ##1 !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle after strobe");
  property p_dark;
    !(panel_on || $past(panel_on) || $past(panel_on, 2)) |->
      !(blk1_vis || blk2_vis || blk3_vis || blk4_vis || cursor_vis);
  endproperty
  a_dark: assert property (p_dark) else $error("visible while panel off");
  property p_pwr;
    $rose(pwr_save) |-> ##[1:2] !panel_on;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power save kept panel on");
  property p_lo_only;
    (wreg && addr == lcdreg_pkg::REG_S1_LO) |=> $stable(block1_start) [*2];
  endproperty
  a_lo_only: assert property (p_lo_only) else $error("low byte moved start");
  property p_hi_commit;
    (wreg && addr == lcdreg_pkg::REG_S1_HI && !wdata[7]) |->
      ##2 {1'b0, block1_start[14:8]} == ($past(wdata, 2) & 8'h7F);
  endproperty
  a_hi_commit: assert property (p_hi_commit) else $error("high byte not live");
  property p_gated;
    (wreg && addr == lcdreg_pkg::REG_S1_HI && wdata[7] && !scroll_permit) ##1 !scroll_permit [*3]
      |-> block1_start == $past(block1_start, 3);
  endproperty
  a_gated: assert property (p_gated) else $error("gated start moved");
  property p_lines;
    (wreg && addr == lcdreg_pkg::REG_L1) |=> block1_lines == $past(wdata);
  endproperty
  a_lines: assert property (p_lines) else $error("line count not loaded");
  property p_cursor;
    (stb && kind == lcdreg_pkg::KIND_MEM) |=> cursor_addr == $past(cursor_addr) + 15'h0001;
  endproperty
  a_cursor: assert property (p_cursor) else $error("cursor not advanced");
  property p_off_wait;
    $rose(panel_on) |-> off_cnt >= OFF_WAIT - 2;
  endproperty
  a_off_wait: assert property (p_off_wait) else $error("panel back on too soon");
endmodule // lcdreg_asserts

// File: verif/lcd_display_control_regs_test.sv
// Self-checking bench for the host controller facing the display control register bank.
`timescale 1ns/1ps
module lcd_display_control_regs_test;
  localparam int OFF_WAIT = 50;
  logic core_clk = 1'b0, nrst = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic frame_tick = 1'b0, dual_panel = 1'b0, scroll_permit = 1'b0, pwr_save = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, stat;
  logic blk1_vis, blk2_vis, blk3_vis, blk4_vis, cursor_vis, panel_on;
  logic [14:0] block1_start, block2_start, cursor_addr, cur0;
  logic [7:0] block1_lines, block2_lines;
  logic [4:0] vis;
  int n_fail = 0;
  int num_checks = 0;
  assign vis = {cursor_vis, blk4_vis, blk3_vis, blk2_vis, blk1_vis};
  always #10 core_clk = ~core_clk;
  lcdreg_link_if lk (.core_clk(core_clk));
  lcdreg_host #(.OFF_WAIT(OFF_WAIT)) i_lcdreg_host (.lk(lk.host), .*);
  lcdreg_dev i_lcdreg_dev (.lk(lk.dev), .*);
  lcdreg_asserts #(.OFF_WAIT(OFF_WAIT)) i_lcdreg_asserts (.stb(lk.stb), .wr(lk.wr),
    .kind(lk.kind), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .*);
  // **********
  // Tasks
  // **********
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bound(input int n);
    if (n >= 100) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  // Ready is held high, so no answer is lost.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    bound(n);
    r = s_axi_bresp;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    bound(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic send(input lcdreg_pkg::lcdreg_kind_type k, input logic [7:0] a,
      input logic [7:0] d, input logic w);
    axw(lcdreg_pkg::HOST_REQ, {13'h0, w, k, d, a}, resp);
    chk("bresp", lcdreg_pkg::RESP_OKAY, resp);
  endtask
  task automatic settle();
    int n;
    n = 0;
    do begin
      axr(lcdreg_pkg::HOST_STAT, stat, resp);
      n++;
    end while (stat[1:0] !== 2'b00 && n < 100);
    bound(n);
    chk("rresp", lcdreg_pkg::RESP_OKAY, resp);
    cyc(2);
  endtask
  task automatic req(input lcdreg_pkg::lcdreg_kind_type k, input logic [7:0] a,
      input logic [7:0] d, input logic w);
    send(k, a, d, w);
    settle();
  endtask
  task automatic rw(input logic [7:0] a, input logic [7:0] d);
    req(lcdreg_pkg::KIND_REG, a, d, 1'b1);
  endtask
  task automatic frame();
    frame_tick <= 1'b1;
    @(posedge core_clk);
    frame_tick <= 1'b0;
    cyc(3);
  endtask
  // A full counter cycle makes totals independent of start phase.
  task automatic flash(input logic [7:0] attr, input logic [39:0] e_on, input logic [39:0] e_up);
    int on_c[5];
    int up_c[5];
    logic [4:0] prev;
    rw(lcdreg_pkg::REG_ATTR, attr);
    frame();
    prev = vis;
    for (int i = 0; i < 5; i++) begin
      on_c[i] = 0;
      up_c[i] = 0;
    end
    repeat (64) begin
      frame();
      for (int i = 0; i < 5; i++) begin
        on_c[i] += int'(vis[i]);
        up_c[i] += int'(vis[i] & !prev[i]);
      end
      prev = vis;
    end
    for (int i = 0; i < 5; i++) begin
      chk("shown frames", e_on[8*i+:8], on_c[i]);
      chk("flash rises", e_up[8*i+:8], up_c[i]);
    end
  endtask
  // **********
  // Sequence
  // **********
  initial begin
    cyc(2);
    nrst <= 1'b1;
    cyc(1);
    chk("panel_on", 0, panel_on);
    chk("block1_start", 0, block1_start);
    axw(4'h8, 32'h0, resp);
    chk("bresp", lcdreg_pkg::RESP_SLVERR, resp);
    axr(4'hC, stat, resp);
    chk("rresp", lcdreg_pkg::RESP_SLVERR, resp);
    $display("test reset done");
    rw(lcdreg_pkg::REG_ATTR, 8'h55);
    chk("vis dark", 0, vis);
    rw(lcdreg_pkg::REG_DISP, 8'h01);
    chk("vis steady", 5'h17, vis);
    dual_panel <= 1'b1;
    cyc(3);
    chk("vis dual", 5'h1F, vis);
    flash(8'hBB, {8'd45, 8'd32, 8'd32, 8'd32, 8'd32}, {8'd1, 8'd16, 8'd2, 8'd16, 8'd2});
    flash(8'h7E, {8'd44, 8'd32, 8'd64, 8'd32, 8'd32}, {8'd2, 8'd16, 8'd0, 8'd16, 8'd16});
    rw(lcdreg_pkg::REG_ATTR, 8'h00);
    chk("vis blank", 0, vis);
    $display("test attributes done");
    cur0 = cursor_addr;
    req(lcdreg_pkg::KIND_MEM, 8'h00, 8'h00, 1'b0);
    chk("cursor after read", cur0 + 15'h1, cursor_addr);
    req(lcdreg_pkg::KIND_REG, lcdreg_pkg::REG_ATTR, 8'h00, 1'b0);
    chk("cursor attr after read", 8'h00, stat[15:8]);
    req(lcdreg_pkg::KIND_MEM, 8'h00, 8'hA5, 1'b1);
    chk("cursor after write", cur0 + 15'h2, cursor_addr);
    req(lcdreg_pkg::KIND_REG, lcdreg_pkg::REG_ATTR, 8'h00, 1'b0);
    chk("cursor attr after write", 8'h01, stat[15:8]);
    $display("test cursor done");
    rw(lcdreg_pkg::REG_S1_LO, 8'h34);
    chk("start1 low only", 15'h0000, block1_start);
    rw(lcdreg_pkg::REG_S1_HI, 8'h12);
    chk("start1", 15'h1234, block1_start);
    rw(lcdreg_pkg::REG_S1_LO, 8'h78);
    rw(lcdreg_pkg::REG_S1_HI, 8'h85);
    chk("start1 gated", 15'h1234, block1_start);
    scroll_permit <= 1'b1;
    cyc(3);
    chk("start1 permitted", 15'h0578, block1_start);
    rw(lcdreg_pkg::REG_L1, 8'h3F);
    chk("lines1", 8'h3F, block1_lines);
    rw(lcdreg_pkg::REG_S2_LO, 8'hAB);
    rw(lcdreg_pkg::REG_S2_HI, 8'h0C);
    chk("start2", 15'h0CAB, block2_start);
    req(lcdreg_pkg::KIND_CMD, lcdreg_pkg::CMD_SCROLL, 8'h00, 1'b1);
    for (int i = 1; i < 7; i++) req(lcdreg_pkg::KIND_PAR, 8'h00, 8'(8'h11 * i), 1'b1);
    chk("scroll start1", 15'h2211, block1_start);
    chk("scroll lines1", 8'h33, block1_lines);
    chk("scroll start2", 15'h5544, block2_start);
    chk("scroll lines2", 8'h66, block2_lines);
    $display("test start addresses done");
    req(lcdreg_pkg::KIND_CMD, lcdreg_pkg::CMD_DISP_OFF, 8'h00, 1'b1);
    req(lcdreg_pkg::KIND_PAR, 8'h00, 8'h00, 1'b1);
    chk("panel off", 0, panel_on);
    send(lcdreg_pkg::KIND_CMD, lcdreg_pkg::CMD_DISP_ON, 8'h00, 1'b1);
    axr(lcdreg_pkg::HOST_STAT, stat, resp);
    chk("on held back", 1'b1, stat[1]);
    chk("panel still off", 0, panel_on);
    settle();
    req(lcdreg_pkg::KIND_PAR, 8'h00, 8'h5A, 1'b1);
    chk("panel on", 1, panel_on);
    req(lcdreg_pkg::KIND_REG, lcdreg_pkg::REG_ATTR, 8'h00, 1'b0);
    chk("attr from command", 8'h5A, stat[15:8]);
    axr(lcdreg_pkg::HOST_REQ, stat, resp);
    chk("request word", 32'h0000000A, stat);
    $display("test commands done");
    pwr_save <= 1'b1;
    cyc(3);
    chk("power save off", 0, panel_on);
    pwr_save <= 1'b0;
    cyc(OFF_WAIT + 10);
    rw(lcdreg_pkg::REG_DISP, 8'h01);
    chk("panel restored", 1, panel_on);
    $display("test power save done");
    tally_and_finish();
  end
endmodule // lcd_display_control_regs_test
